// *** shared/sbe_pkg.sv ***
package sbe_pkg;

    // =====================================================================
    // Widths and stack layout
    localparam int          XLEN        = 32;
    localparam int          LVL_W       = 3;
    localparam int          IDX_W       = 3;
    localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
    localparam logic [2:0]  IRQ_FRAME   = 3'h7;
    localparam logic [2:0]  EXC_FRAME   = 3'h2;
    localparam logic [2:0]  IDX_PC      = 3'h0;
    localparam logic [2:0]  IDX_SR      = 3'h1;
    localparam logic [3:0]  REG_TOP     = 4'hE;
    localparam logic [3:0]  REG_LOW     = 4'h8;
    localparam logic [3:0]  REG_HIGH    = 4'hC;

    // =====================================================================
    // Status word layout and reset values
    localparam int          SR_LVL_LSB  = 22;
    localparam int          SR_LVL_MSB  = 24;
    localparam logic [31:0] SR_RESET    = 32'h0000_0000;
    localparam logic [31:0] SP_RESET    = 32'h0000_1000;

    // =====================================================================
    // Priority classes
    localparam logic [2:0]  LVL_NONE    = 3'h0;
    localparam logic [2:0]  LVL_IRQ_TOP = 3'h4;
    localparam logic [2:0]  LVL_EXC     = 3'h5;

    // =====================================================================
    // Handler offsets from the exception vector base
    localparam logic [31:0] OFS_ABORT   = 32'h0000_0010;
    localparam logic [31:0] OFS_ILLEGAL = 32'h0000_0020;
    localparam logic [31:0] OFS_SCALL   = 32'h0000_0100;

    typedef enum logic [1:0] {
        SBE_IDLE,
        SBE_PUSH,
        SBE_POP
    } sbe_state_t;

endpackage

// *** logic/sbe_prot_check.sv ***
`timescale 1ns/1ps

module sbe_prot_check #(
    parameter int AW = 32
) (
    input  wire logic          prot_en,
    input  wire logic          acc_req,
    input  wire logic          acc_priv,
    input  wire logic [AW-1:0] acc_addr,
    input  wire logic [AW-1:0] prot_base,
    input  wire logic [AW-1:0] prot_limit,
    output wire logic          violation
);

    // =====================================================================
    // Unprivileged access must fall inside [base, limit)
    wire in_region = (acc_addr >= prot_base) && (acc_addr < prot_limit);

    assign violation = prot_en && acc_req && !acc_priv && !in_region;

endmodule

// *** logic/sbe_exc_unit.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - Interrupt entry pushes R8-R12 automatically
// - Same register push for every level
// - Interrupt entry also pushes return address, status
// - Interrupt return restores R8-R12, status, address
// - Exceptions and scall stack status and address
// - Return instructions pop status, resume at popped
// - No shadow banks or return registers
// - Four external interrupt levels, own contexts
// - Fixed priority among simultaneous exception sources
// - Higher class preempts lower class handler
// - Protection violation aborts access, raises exception
module sbe_exc_unit #(
    parameter logic [31:0] VEC_BASE = 32'h0000_0000
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  irq_req,
    input  wire logic [31:0] irq_vector,
    output wire logic        irq_ack,
    input  wire logic        illegal_op,
    input  wire logic        scall_req,
    input  wire logic        rete_req,
    input  wire logic        rets_req,
    input  wire logic [31:0] cur_pc,
    input  wire logic [31:0] next_pc,
    input  wire logic        dacc_req,
    input  wire logic        dacc_priv,
    input  wire logic [31:0] dacc_addr,
    output wire logic        dacc_go,
    input  wire logic        prot_en,
    input  wire logic [31:0] prot_base,
    input  wire logic [31:0] prot_limit,
    output wire logic [3:0]  reg_raddr,
    input  wire logic [31:0] reg_rdata,
    output logic             reg_wen,
    output logic      [3:0]  reg_waddr,
    output logic      [31:0] reg_wdata,
    output logic             stk_req,
    output logic             stk_we,
    output logic      [31:0] stk_addr,
    output logic      [31:0] stk_wdata,
    input  wire logic        stk_ack,
    input  wire logic [31:0] stk_rdata,
    input  wire logic        sr_wen,
    input  wire logic [31:0] sr_wdata,
    output logic      [31:0] sr,
    output logic      [31:0] sp,
    output logic             redirect,
    output logic      [31:0] redirect_pc,
    output wire logic        busy
);

    // =====================================================================
    // State
    sbe_pkg::sbe_state_t state;
    logic        [2:0]  idx;
    logic        [2:0]  frame_len;
    logic        [2:0]  entry_lvl;
    logic        [31:0] entry_tgt;
    logic        [31:0] ret_pc;
    logic        [31:0] saved_sr;
    logic               abort_flag;
    logic        [31:0] abort_pc;
    logic               from_push;
    logic        [31:0] seq_sp;

    // =====================================================================
    // Protection check on core data accesses
    wire dacc_viol;

    sbe_prot_check #(
        .AW (sbe_pkg::XLEN)
    ) u_prot (
        .prot_en    (prot_en),
        .acc_req    (dacc_req),
        .acc_priv   (dacc_priv),
        .acc_addr   (dacc_addr),
        .prot_base  (prot_base),
        .prot_limit (prot_limit),
        .violation  (dacc_viol)
    );

    assign dacc_go = dacc_req && !dacc_viol;

    // =====================================================================
    // Priority resolution
    wire [2:0] cur_lvl = sr[sbe_pkg::SR_LVL_MSB:sbe_pkg::SR_LVL_LSB];
    wire [2:0] irq_lvl = irq_req[3] ? 3'h4 :
                         irq_req[2] ? 3'h3 :
                         irq_req[1] ? 3'h2 :
                         irq_req[0] ? 3'h1 : sbe_pkg::LVL_NONE;
    wire       idle     = (state == sbe_pkg::SBE_IDLE);
    wire       sync_exc = abort_flag || illegal_op || scall_req;
    wire       ret_any  = rete_req || rets_req;
    wire       irq_take = idle && !sync_exc && !ret_any && (irq_lvl > cur_lvl);
    wire       exc_take = idle && sync_exc;
    wire       ret_take = idle && !sync_exc && ret_any;
    wire       cur_irq  = (cur_lvl != sbe_pkg::LVL_NONE) && (cur_lvl <= sbe_pkg::LVL_IRQ_TOP);

    // Abort, then illegal opcode, then scall, then interrupts
    wire [31:0] exc_tgt = abort_flag ? VEC_BASE + sbe_pkg::OFS_ABORT :
                          illegal_op ? VEC_BASE + sbe_pkg::OFS_ILLEGAL :
                                       VEC_BASE + sbe_pkg::OFS_SCALL;
    wire [31:0] exc_ret = abort_flag ? abort_pc :
                          illegal_op ? cur_pc : next_pc;
    wire [2:0]  exc_lvl = (abort_flag || illegal_op) ? sbe_pkg::LVL_EXC : cur_lvl;
    wire [2:0]  ret_len = (rete_req && cur_irq) ? sbe_pkg::IRQ_FRAME : sbe_pkg::EXC_FRAME;

    assign irq_ack = irq_take;
    assign busy    = !idle;

    // =====================================================================
    // Stack item selection: 0 address, 1 status, 2..6 R12 down to R8
    wire [3:0]  item_reg  = sbe_pkg::REG_TOP - {1'b0, idx};
    wire [31:0] push_data = (idx == sbe_pkg::IDX_PC) ? ret_pc :
                            (idx == sbe_pkg::IDX_SR) ? saved_sr : reg_rdata;
    wire        last_push = (idx == frame_len - 3'h1);
    wire [31:0] sp_dec    = sp - sbe_pkg::WORD_BYTES;
    wire [31:0] sp_inc    = sp + sbe_pkg::WORD_BYTES;
    wire [31:0] sr_entry  = {sr[31:sbe_pkg::SR_LVL_MSB+1], entry_lvl,
                             sr[sbe_pkg::SR_LVL_LSB-1:0]};
    wire        beat      = stk_req && stk_ack;

    assign reg_raddr = item_reg;

    // =====================================================================
    // Abort latch, set wins over clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            abort_flag <= 1'b0;
            abort_pc   <= 32'h0000_0000;
        end else if (dacc_viol) begin
            abort_flag <= 1'b1;
            abort_pc   <= cur_pc;
        end else if (exc_take) begin
            abort_flag <= 1'b0;
        end
    end

    // =====================================================================
    // Entry and return sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= sbe_pkg::SBE_IDLE;
            idx         <= 3'h0;
            frame_len   <= 3'h0;
            entry_lvl   <= sbe_pkg::LVL_NONE;
            entry_tgt   <= 32'h0000_0000;
            ret_pc      <= 32'h0000_0000;
            saved_sr    <= sbe_pkg::SR_RESET;
            sr          <= sbe_pkg::SR_RESET;
            sp          <= sbe_pkg::SP_RESET;
            seq_sp      <= sbe_pkg::SP_RESET;
            stk_req     <= 1'b0;
            stk_we      <= 1'b0;
            stk_addr    <= 32'h0000_0000;
            stk_wdata   <= 32'h0000_0000;
            reg_wen     <= 1'b0;
            reg_waddr   <= 4'h0;
            reg_wdata   <= 32'h0000_0000;
            redirect    <= 1'b0;
            redirect_pc <= 32'h0000_0000;
            from_push   <= 1'b0;
        end else begin
            reg_wen  <= 1'b0;
            redirect <= 1'b0;
            case (state)
                sbe_pkg::SBE_IDLE: begin
                    seq_sp   <= sp;
                    saved_sr <= sr;
                    idx      <= 3'h0;
                    if (irq_take) begin
                        state     <= sbe_pkg::SBE_PUSH;
                        frame_len <= sbe_pkg::IRQ_FRAME;
                        entry_lvl <= irq_lvl;
                        entry_tgt <= irq_vector;
                        ret_pc    <= next_pc;
                    end else if (exc_take) begin
                        state     <= sbe_pkg::SBE_PUSH;
                        frame_len <= sbe_pkg::EXC_FRAME;
                        entry_lvl <= exc_lvl;
                        entry_tgt <= exc_tgt;
                        ret_pc    <= exc_ret;
                    end else if (ret_take) begin
                        state     <= sbe_pkg::SBE_POP;
                        frame_len <= ret_len;
                        idx       <= ret_len - 3'h1;
                    end else if (sr_wen) begin
                        sr <= sr_wdata;
                    end
                end
                sbe_pkg::SBE_PUSH: begin
                    if (!stk_req) begin
                        stk_req   <= 1'b1;
                        stk_we    <= 1'b1;
                        stk_addr  <= sp_dec;
                        stk_wdata <= push_data;
                    end else if (stk_ack) begin
                        stk_req <= 1'b0;
                        sp      <= sp_dec;
                        idx     <= idx + 3'h1;
                        if (last_push) begin
                            state       <= sbe_pkg::SBE_IDLE;
                            sr          <= sr_entry;
                            redirect    <= 1'b1;
                            redirect_pc <= entry_tgt;
                            from_push   <= 1'b1;
                        end
                    end
                end
                sbe_pkg::SBE_POP: begin
                    if (!stk_req) begin
                        stk_req  <= 1'b1;
                        stk_we   <= 1'b0;
                        stk_addr <= sp;
                    end else if (stk_ack) begin
                        stk_req <= 1'b0;
                        sp      <= sp_inc;
                        idx     <= idx - 3'h1;
                        if (idx > sbe_pkg::IDX_SR) begin
                            reg_wen   <= 1'b1;
                            reg_waddr <= item_reg;
                            reg_wdata <= stk_rdata;
                        end else if (idx == sbe_pkg::IDX_SR) begin
                            sr <= stk_rdata;
                        end else begin
                            state       <= sbe_pkg::SBE_IDLE;
                            redirect    <= 1'b1;
                            redirect_pc <= stk_rdata;
                            from_push   <= 1'b0;
                        end
                    end
                end
                default: begin
                    state   <= sbe_pkg::SBE_IDLE;
                    stk_req <= 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // Checks
    wire [31:0] frame_bytes = {27'h0, frame_len, 2'h0};

    irq_frame_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (redirect && from_push && frame_len == sbe_pkg::IRQ_FRAME)
        |-> (sp == seq_sp - 32'h0000_001C))
        else $error("interrupt frame not seven words");
    exc_frame_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (redirect && from_push && frame_len == sbe_pkg::EXC_FRAME)
        |-> (sp == seq_sp - 32'h0000_0008))
        else $error("exception frame not two words");
    first_item_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (stk_req && stk_we && idx == sbe_pkg::IDX_PC) |-> (stk_wdata == ret_pc))
        else $error("return address not pushed first");

    push_addr_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (stk_req && stk_we) |-> (stk_addr == sp_dec) && ($rose(stk_req) || $stable(stk_wdata)))
        else $error("push not predecrement");

    pop_balance_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (redirect && !from_push) |-> (sp == seq_sp + frame_bytes))
        else $error("stack pointer not restored");

    reg_restore_a: assert property (@(posedge core_clk) disable iff (!resetn)
        reg_wen |-> (reg_waddr >= sbe_pkg::REG_LOW) && (reg_waddr <= sbe_pkg::REG_HIGH)
        && $past(beat) && (reg_wdata == $past(stk_rdata)))
        else $error("bad register restore");

    resume_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (redirect && !from_push) |-> (redirect_pc == $past(stk_rdata)) && $past(beat))
        else $error("resume not at popped address");

    entry_lvl_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (redirect && from_push) |-> (cur_lvl == entry_lvl) && (redirect_pc == entry_tgt))
        else $error("handler level or target wrong");

    preempt_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (idle && !sync_exc && !ret_any && irq_lvl > cur_lvl)
        |=> (state == sbe_pkg::SBE_PUSH) && (frame_len == sbe_pkg::IRQ_FRAME))
        else $error("higher interrupt not taken");

    no_lower_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (idle && !sync_exc && !ret_any && irq_lvl <= cur_lvl) |-> !irq_ack ##1 idle)
        else $error("lower interrupt preempted");

    abort_prio_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (idle && abort_flag && illegal_op)
        |=> (entry_tgt == VEC_BASE + sbe_pkg::OFS_ABORT))
        else $error("abort did not win priority");

    abort_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
        dacc_viol |-> !dacc_go ##1 abort_flag)
        else $error("violating access not aborted");
endmodule

// *** test/sbe_irq_ctrl.sv ***
`timescale 1ns/1ps

// =====================================================================
// Outside interrupt controller: latches sources, offers the highest
module sbe_irq_ctrl (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  src,
    input  wire logic        irq_ack,
    output logic      [3:0]  irq_req,
    output logic      [31:0] irq_vector
);
    logic [1:0] win;

    always_comb begin
        win = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (irq_req[i]) win = i[1:0];
        end
    end

    assign irq_vector = 32'h0000_0200 + {24'h0, win, 6'h0};

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) irq_req <= 4'h0;
        else irq_req <= (irq_req | src) & ~(irq_ack ? 4'h1 << win : 4'h0);
    end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    // =================================================================
    // Signals and models
    logic        core_clk, resetn, irq_ack, illegal_op, scall_req, rete_req, rets_req;
    logic        dacc_req, dacc_priv, dacc_go, prot_en, reg_wen, stk_req, stk_we, stk_ack;
    logic        redirect, busy, sr_wen;
    logic [3:0]  irq_req, irq_src, reg_raddr, reg_waddr;
    logic [31:0] irq_vector, cur_pc, next_pc, dacc_addr, prot_base, prot_limit, reg_rdata;
    logic [31:0] reg_wdata, stk_addr, stk_wdata, stk_rdata, sr, sp, redirect_pc, sr_wdata;
    logic [31:0] mem [0:1023];
    logic [31:0] regs [0:15];
    int          mismatches = 0;
    int          tests_run = 0;
    int          lat = 0;
    int          cnt = 0;

    sbe_irq_ctrl ctrl (.core_clk(core_clk), .resetn(resetn), .src(irq_src),
        .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector));

    sbe_exc_unit #(.VEC_BASE(32'h0000_8000)) dut (.core_clk(core_clk), .resetn(resetn),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .illegal_op(illegal_op), .scall_req(scall_req), .rete_req(rete_req),
        .rets_req(rets_req), .cur_pc(cur_pc), .next_pc(next_pc), .dacc_req(dacc_req),
        .dacc_priv(dacc_priv), .dacc_addr(dacc_addr), .dacc_go(dacc_go),
        .prot_en(prot_en), .prot_base(prot_base), .prot_limit(prot_limit),
        .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .reg_wen(reg_wen),
        .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .stk_req(stk_req), .stk_we(stk_we),
        .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_ack(stk_ack),
        .stk_rdata(stk_rdata), .sr_wen(sr_wen), .sr_wdata(sr_wdata), .sr(sr), .sp(sp),
        .redirect(redirect), .redirect_pc(redirect_pc), .busy(busy));

    assign reg_rdata = regs[reg_raddr];

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Stack memory with set ack latency; idle bus shows inverted data
    always @(negedge core_clk) begin
        stk_ack <= stk_req && cnt >= lat;
        stk_rdata <= stk_req ? mem[stk_addr[11:2]] : ~stk_rdata;
        cnt <= stk_req ? cnt + 1 : 0;
    end

    always @(posedge core_clk) begin
        if (stk_req && stk_ack && stk_we) mem[stk_addr[11:2]] <= stk_wdata;
        if (reg_wen) regs[reg_waddr] <= reg_wdata;
    end

    // =================================================================
    // Helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    function logic [31:0] at(input logic [31:0] a);
        return mem[a[11:2]];
    endfunction

    task fire(input logic [3:0] ev);
        @(negedge core_clk);
        {illegal_op, scall_req, rete_req, rets_req} = ev;
        @(negedge core_clk);
        {illegal_op, scall_req, rete_req, rets_req} = 4'h0;
        check({31'h0, busy}, 32'h0000_0001);
    endtask

    task raise(input int k);
        @(negedge core_clk);
        irq_src = 4'h1 << k;
        @(negedge core_clk);
        irq_src = 4'h0;
    endtask

    task expect_end(input logic [31:0] pc, input logic [31:0] spv, input logic [2:0] lvl);
        int n;
        n = 0;
        while (redirect !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 200) mismatches++;
        check({31'h0, busy}, 32'h0000_0000);
        check(redirect_pc, pc);
        check(sp, spv);
        check({29'h0, sr[24:22]}, {29'h0, lvl});
    endtask

    task set_regs(input logic [31:0] b);
        for (int r = 8; r <= 12; r++) regs[r] = b + r;
    endtask

    task check_frame(input logic [31:0] top, input logic [31:0] pc, input logic [31:0] s,
                     input logic [31:0] b);
        check(at(top - 32'h4), pc);
        check(at(top - 32'h8), s);
        for (int r = 12; r >= 8; r--) check(at(top - 32'(4 * (15 - r))), b + r);
    endtask

    task check_regs(input logic [31:0] b);
        for (int r = 8; r <= 12; r++) check(regs[r], b + r);
    endtask

    // =================================================================
    // Scenarios
    task test_irq_nest();
        lat = 2;
        set_regs(32'hA000_0000);
        next_pc = 32'h0000_0400;
        raise(0);
        expect_end(32'h0000_0200, 32'h0000_0FE4, 3'h1);
        check_frame(32'h0000_1000, 32'h0000_0400, 32'h0000_0000, 32'hA000_0000);
        set_regs(32'hB000_0000);
        next_pc = 32'h0000_0480;
        lat = 0;
        raise(3);
        expect_end(32'h0000_02C0, 32'h0000_0FC8, 3'h4);
        check_frame(32'h0000_0FE4, 32'h0000_0480, 32'h0040_0000, 32'hB000_0000);
        set_regs(32'hC000_0000);
        fire(4'h2);
        expect_end(32'h0000_0480, 32'h0000_0FE4, 3'h1);
        check_regs(32'hB000_0000);
        lat = 3;
        fire(4'h2);
        expect_end(32'h0000_0400, 32'h0000_1000, 3'h0);
        check_regs(32'hA000_0000);
        $display("test irq_nest done");
    endtask

    task test_exc();
        cur_pc = 32'h0000_0600;
        next_pc = 32'h0000_0604;
        fire(4'hC);
        expect_end(32'h0000_8020, 32'h0000_0FF8, 3'h5);
        check(at(32'h0000_0FFC), 32'h0000_0600);
        fire(4'h2);
        expect_end(32'h0000_0600, 32'h0000_1000, 3'h0);
        fire(4'h4);
        expect_end(32'h0000_8100, 32'h0000_0FF8, 3'h0);
        check(at(32'h0000_0FFC), 32'h0000_0604);
        fire(4'h1);
        expect_end(32'h0000_0604, 32'h0000_1000, 3'h0);
        $display("test exc done");
    endtask

    task test_abort();
        @(negedge core_clk);
        {prot_en, prot_base, prot_limit} = {1'h1, 32'h0000_2000, 32'h0000_3000};
        {dacc_req, dacc_priv, dacc_addr, cur_pc} = {2'h2, 32'h0000_2100, 32'h0000_0500};
        #1 check({31'h0, dacc_go}, 32'h1);
        @(negedge core_clk);
        dacc_addr = 32'h0000_3000;
        #1 check({31'h0, dacc_go}, 32'h0);
        @(negedge core_clk);
        {dacc_req, illegal_op} = 2'h1;
        @(negedge core_clk);
        illegal_op = 1'h0;
        expect_end(32'h0000_8010, 32'h0000_0FF8, 3'h5);
        check(at(32'h0000_0FFC), 32'h0000_0500);
        fire(4'h2);
        expect_end(32'h0000_0500, 32'h0000_1000, 3'h0);
        $display("test abort done");
    endtask

    task test_lower();
        next_pc = 32'h0000_0700;
        @(negedge core_clk);
        {sr_wen, sr_wdata} = {1'h1, 32'h00C0_0000};
        @(negedge core_clk);
        sr_wen = 1'h0;
        check({29'h0, sr[24:22]}, 32'h0000_0003);
        raise(1);
        repeat (4) @(negedge core_clk);
        check({30'h0, busy, irq_ack}, 32'h0000_0000);
        check(sp, 32'h0000_1000);
        {sr_wen, sr_wdata} = {1'h1, 32'h0000_0000};
        @(negedge core_clk);
        sr_wen = 1'h0;
        expect_end(32'h0000_0240, 32'h0000_0FE4, 3'h2);
        check_frame(32'h0000_1000, 32'h0000_0700, 32'h0000_0000, 32'hA000_0000);
        fire(4'h2);
        expect_end(32'h0000_0700, 32'h0000_1000, 3'h0);
        check_regs(32'hA000_0000);
        $display("test lower done");
    endtask

    task print_verdict();
        $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {resetn, irq_src, illegal_op, scall_req, rete_req, rets_req} = '0;
        {cur_pc, next_pc, dacc_req, dacc_priv, dacc_addr} = '0;
        {prot_en, prot_base, prot_limit, sr_wen, sr_wdata} = '0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        check(sp, 32'h0000_1000);
        test_irq_nest();
        test_exc();
        test_abort();
        test_lower();
        print_verdict();
    end

    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
endmodule
